/* File: ppio_params.svh */
// Register addresses, control word fields and reset values of the parallel port block.
`ifndef PPIO_PARAMS_SVH
`define PPIO_PARAMS_SVH

// ----------------------------------------------------------------------------
// Port address decode
// ----------------------------------------------------------------------------
`define PPIO_ADDR_PORT_A 2'h0
`define PPIO_ADDR_PORT_B 2'h1
`define PPIO_ADDR_PORT_C 2'h2
`define PPIO_ADDR_CTRL 2'h3

// ----------------------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------------------
`define PPIO_CW_MODE_SET 7
`define PPIO_CW_GA_MODE_HI 6
`define PPIO_CW_GA_MODE_LO 5
`define PPIO_CW_PA_IN 4
`define PPIO_CW_PCU_IN 3
`define PPIO_CW_GB_MODE 2
`define PPIO_CW_PB_IN 1
`define PPIO_CW_PCL_IN 0
`define PPIO_CW_BIT_SEL_HI 3
`define PPIO_CW_BIT_SEL_LO 1
`define PPIO_CW_BIT_VAL 0

// Port C bits whose single-bit writes also drive the interrupt enable flags.
`define PPIO_PC_IRQ_ENABLE_FLAG_A_IN 3'h4
`define PPIO_PC_IRQ_ENABLE_FLAG_A_OUT 3'h6
`define PPIO_PC_IRQ_ENABLE_FLAG_B 3'h2

// Port C bits claimed as control lines in the handshake modes.
`define PPIO_CTL_A_M1_OUT 8'hc8
`define PPIO_CTL_A_M1_IN 8'h38
`define PPIO_CTL_A_M2 8'hf8
`define PPIO_CTL_B_M1 8'h07

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PPIO_CTRL_RST 8'h00
`define PPIO_DATA_RST 8'h00
`define PPIO_PIN_IDLE 14'h1c00

`endif

/* File: ppio_pkg.sv */
// Types shared by the parallel port block.
`default_nettype none
package ppio_pkg;
	typedef enum logic [2:0] {
		PPIO_MODE0 = 3'b001,
		PPIO_MODE1 = 3'b010,
		PPIO_MODE2 = 3'b100
	} ppio_mode_t;
endpackage : ppio_pkg
`default_nettype wire

/* File: ppio_bus_if.sv */
// Internal carrier between the host front end and the port core.
`default_nettype none
interface ppio_bus_if;
	logic wr_stb;
	logic rd_en;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic ext_reset;
	modport front (output wr_stb, output rd_en, output addr, output wdata, output ext_reset);
	modport core (input wr_stb, input rd_en, input addr, input wdata, input ext_reset);
endinterface : ppio_bus_if
`default_nettype wire

/* File: ppio_host_front.sv */
// Host bus front end: pin synchronisers and write/read strobe detection.
`default_nettype none
`include "ppio_params.svh"
module ppio_host_front import ppio_pkg::*; (
	input wire logic i_core_clk, // Core clock.
	input wire logic i_rstn, // Synchronous reset, active low.
	input wire logic i_cs_n, // Device select pin.
	input wire logic i_rd_n, // Read strobe pin.
	input wire logic i_wr_n, // Write strobe pin.
	input wire logic i_port_select_lo, // Address bit 0 pin.
	input wire logic i_port_select_hi, // Address bit 1 pin.
	input wire logic i_reset, // Device reset pin, active high.
	input wire logic [7:0] i_data, // Data bus pins, input side.
	ppio_bus_if.front bus // Decoded host requests.
);
	logic [13:0] meta_ff;
	logic [13:0] sync_ff;
	logic wr_prev_ff;
	logic cap_sel_ff;
	logic [1:0] cap_addr_ff;
	logic [7:0] cap_data_ff;
	wire logic [13:0] pins = {i_reset, i_cs_n, i_rd_n, i_wr_n, i_port_select_hi, i_port_select_lo, i_data};
	wire logic s_reset = sync_ff[13];
	wire logic s_cs_n = sync_ff[12];
	wire logic s_rd_n = sync_ff[11];
	wire logic s_wr_n = sync_ff[10];
	wire logic [1:0] s_addr = sync_ff[9:8];
	wire logic [7:0] s_data = sync_ff[7:0];
	// The write is taken at the trailing edge, where data setup is guaranteed.
	wire logic wr_rise = s_wr_n && !wr_prev_ff && cap_sel_ff;

	// ------------------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			meta_ff <= `PPIO_PIN_IDLE;
			sync_ff <= `PPIO_PIN_IDLE;
		end else begin
			meta_ff <= pins;
			sync_ff <= meta_ff;
		end
	end

	// ------------------------------------------------------------------------
	// Strobe capture
	// ------------------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			wr_prev_ff <= 1'b1;
			cap_sel_ff <= 1'b0;
			cap_addr_ff <= 2'h0;
			cap_data_ff <= `PPIO_DATA_RST;
		end else begin
			wr_prev_ff <= s_wr_n;
			if (!s_wr_n) begin
				cap_sel_ff <= !s_cs_n;
				cap_addr_ff <= s_addr;
				cap_data_ff <= s_data;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			bus.wr_stb <= 1'b0;
			bus.rd_en <= 1'b0;
			bus.addr <= 2'h0;
			bus.wdata <= `PPIO_DATA_RST;
			bus.ext_reset <= 1'b0;
		end else begin
			bus.wr_stb <= wr_rise;
			bus.rd_en <= !s_cs_n && !s_rd_n;
			bus.addr <= wr_rise ? cap_addr_ff : s_addr;
			bus.wdata <= cap_data_ff;
			bus.ext_reset <= s_reset;
		end
	end
endmodule : ppio_host_front
`default_nettype wire

/* File: ppio_port.sv */
// Programmable parallel port core: control word, port latches, pin drivers and host read-back.
`default_nettype none
`include "ppio_params.svh"
module ppio_port import ppio_pkg::*; (
	input wire logic i_core_clk, // Core clock, 20 MHz.
	input wire logic i_rstn, // Synchronous reset, active low.
	input wire logic i_cs_n, // Device select, active low.
	input wire logic i_rd_n, // Read strobe, active low.
	input wire logic i_wr_n, // Write strobe, active low.
	input wire logic i_port_select_lo, // Address bit 0.
	input wire logic i_port_select_hi, // Address bit 1.
	input wire logic i_reset, // Device reset pin, active high.
	input wire logic [7:0] i_data, // Data bus, input side.
	output logic [7:0] o_data, // Data bus, output side.
	output logic [7:0] o_data_oe_n, // Data bus enables, low drives.
	input wire logic [7:0] i_pa, // Port A pins, input side.
	output logic [7:0] o_pa, // Port A pins, output side.
	output logic [7:0] o_pa_oe_n, // Port A enables, low drives.
	input wire logic [7:0] i_pb, // Port B pins, input side.
	output logic [7:0] o_pb, // Port B pins, output side.
	output logic [7:0] o_pb_oe_n, // Port B enables, low drives.
	input wire logic [7:0] i_pc, // Port C pins, input side.
	output logic [7:0] o_pc, // Port C pins, output side.
	output logic [7:0] o_pc_oe_n // Port C enables, low drives.
);
	// ------------------------------------------------------------------------
	// Host front end
	// ------------------------------------------------------------------------
	ppio_bus_if u_bus ();

	ppio_host_front u_front (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_cs_n(i_cs_n),
		.i_rd_n(i_rd_n),
		.i_wr_n(i_wr_n),
		.i_port_select_lo(i_port_select_lo),
		.i_port_select_hi(i_port_select_hi),
		.i_reset(i_reset),
		.i_data(i_data),
		.bus(u_bus.front)
	);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	logic [7:0] ctrl_ff;
	logic cfg_done_ff;
	logic [7:0] pa_out_ff;
	logic [7:0] pb_out_ff;
	logic [7:0] pc_out_ff;
	logic irq_enable_flag_a_in_ff;
	logic irq_enable_flag_a_out_ff;
	logic irq_enable_flag_b_ff;
	logic [7:0] data_ff;
	logic [7:0] data_oe_n_ff;
	logic [7:0] pa_oe_n_ff;
	logic [7:0] pb_oe_n_ff;
	logic [7:0] pc_oe_n_ff;
	logic [7:0] pa_meta_ff;
	logic [7:0] pa_sync_ff;
	logic [7:0] pb_meta_ff;
	logic [7:0] pb_sync_ff;
	logic [7:0] pc_meta_ff;
	logic [7:0] pc_sync_ff;

	// ------------------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------------------
	wire logic clear = !i_rstn || u_bus.ext_reset;
	wire logic wr_a = u_bus.wr_stb && (u_bus.addr == `PPIO_ADDR_PORT_A);
	wire logic wr_b = u_bus.wr_stb && (u_bus.addr == `PPIO_ADDR_PORT_B);
	wire logic wr_c = u_bus.wr_stb && (u_bus.addr == `PPIO_ADDR_PORT_C);
	wire logic wr_ctrl = u_bus.wr_stb && (u_bus.addr == `PPIO_ADDR_CTRL);
	wire logic wr_mode = wr_ctrl && u_bus.wdata[`PPIO_CW_MODE_SET];
	wire logic wr_bit = wr_ctrl && !u_bus.wdata[`PPIO_CW_MODE_SET];
	wire logic [2:0] bit_sel = u_bus.wdata[`PPIO_CW_BIT_SEL_HI:`PPIO_CW_BIT_SEL_LO];
	wire logic bit_val = u_bus.wdata[`PPIO_CW_BIT_VAL];
	// A read of the control address is illegal; the bus stays floating.
	wire logic rd_legal = u_bus.rd_en && (u_bus.addr != `PPIO_ADDR_CTRL);

	// ------------------------------------------------------------------------
	// Mode and direction decode
	// ------------------------------------------------------------------------
	ppio_mode_t ga_mode;
	ppio_mode_t gb_mode;
	assign ga_mode = ctrl_ff[`PPIO_CW_GA_MODE_HI] ? PPIO_MODE2 :
		(ctrl_ff[`PPIO_CW_GA_MODE_LO] ? PPIO_MODE1 : PPIO_MODE0);
	assign gb_mode = ctrl_ff[`PPIO_CW_GB_MODE] ? PPIO_MODE1 : PPIO_MODE0;

	wire logic pa_in_cw = ctrl_ff[`PPIO_CW_PA_IN];
	logic [7:0] a_ctl;
	logic [7:0] b_ctl;
	always_comb begin
		case (ga_mode)
			PPIO_MODE0: a_ctl = 8'h00;
			PPIO_MODE1: a_ctl = pa_in_cw ? `PPIO_CTL_A_M1_IN : `PPIO_CTL_A_M1_OUT;
			PPIO_MODE2: a_ctl = `PPIO_CTL_A_M2;
			default: a_ctl = 8'h00;
		endcase
	end
	always_comb begin
		case (gb_mode)
			PPIO_MODE0: b_ctl = 8'h00;
			PPIO_MODE1: b_ctl = `PPIO_CTL_B_M1;
			default: b_ctl = 8'h00;
		endcase
	end

	// Direction bits are one for input; control lines are left undriven here.
	wire logic pa_is_in = !cfg_done_ff || pa_in_cw || (ga_mode == PPIO_MODE2);
	wire logic pb_is_in = !cfg_done_ff || ctrl_ff[`PPIO_CW_PB_IN];
	wire logic [7:0] pc_half_in = {{4{ctrl_ff[`PPIO_CW_PCU_IN]}}, {4{ctrl_ff[`PPIO_CW_PCL_IN]}}};
	wire logic [7:0] pc_is_in = cfg_done_ff ? (pc_half_in | a_ctl | b_ctl) : 8'hff;

	// ------------------------------------------------------------------------
	// Read-back selection
	// ------------------------------------------------------------------------
	logic [7:0] pc_view;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pc_view
			assign pc_view[gi] = pc_is_in[gi] ? pc_sync_ff[gi] : pc_out_ff[gi];
		end
	endgenerate

	// In the handshake modes the enable flags replace their port C bits.
	logic [7:0] pc_rd;
	always_comb begin
		pc_rd = pc_view;
		case (ga_mode)
			PPIO_MODE1: begin
				if (pa_in_cw) begin
					pc_rd[`PPIO_PC_IRQ_ENABLE_FLAG_A_IN] = irq_enable_flag_a_in_ff;
				end else begin
					pc_rd[`PPIO_PC_IRQ_ENABLE_FLAG_A_OUT] = irq_enable_flag_a_out_ff;
				end
			end
			PPIO_MODE2: begin
				pc_rd[`PPIO_PC_IRQ_ENABLE_FLAG_A_IN] = irq_enable_flag_a_in_ff;
				pc_rd[`PPIO_PC_IRQ_ENABLE_FLAG_A_OUT] = irq_enable_flag_a_out_ff;
			end
			default: pc_rd = pc_view;
		endcase
		if (gb_mode == PPIO_MODE1) begin
			pc_rd[`PPIO_PC_IRQ_ENABLE_FLAG_B] = irq_enable_flag_b_ff;
		end
	end

	wire logic [7:0] pa_rd = pa_is_in ? pa_sync_ff : pa_out_ff;
	wire logic [7:0] pb_rd = pb_is_in ? pb_sync_ff : pb_out_ff;
	wire logic [7:0] nxt_data = (u_bus.addr == `PPIO_ADDR_PORT_A) ? pa_rd :
		(u_bus.addr == `PPIO_ADDR_PORT_B) ? pb_rd : pc_rd;
	// Port C writes keep the input-half bits so that they never leak out later.
	wire logic [7:0] nxt_pc_wr = (pc_out_ff & pc_is_in) | (u_bus.wdata & ~pc_is_in);

	// ------------------------------------------------------------------------
	// Port pin synchronisers
	// ------------------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			pa_meta_ff <= `PPIO_DATA_RST;
			pa_sync_ff <= `PPIO_DATA_RST;
			pb_meta_ff <= `PPIO_DATA_RST;
			pb_sync_ff <= `PPIO_DATA_RST;
			pc_meta_ff <= `PPIO_DATA_RST;
			pc_sync_ff <= `PPIO_DATA_RST;
		end else begin
			pa_meta_ff <= i_pa;
			pa_sync_ff <= pa_meta_ff;
			pb_meta_ff <= i_pb;
			pb_sync_ff <= pb_meta_ff;
			pc_meta_ff <= i_pc;
			pc_sync_ff <= pc_meta_ff;
		end
	end

	// ------------------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (clear) begin
			ctrl_ff <= `PPIO_CTRL_RST;
			cfg_done_ff <= 1'b0;
		end else if (wr_mode) begin
			ctrl_ff <= u_bus.wdata;
			cfg_done_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// Port output latches
	// ------------------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (clear || wr_mode) begin
			pa_out_ff <= `PPIO_DATA_RST;
			pb_out_ff <= `PPIO_DATA_RST;
		end else begin
			if (wr_a) begin
				pa_out_ff <= u_bus.wdata;
			end
			if (wr_b) begin
				pb_out_ff <= u_bus.wdata;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (clear || wr_mode) begin
			pc_out_ff <= `PPIO_DATA_RST;
		end else if (wr_c) begin
			pc_out_ff <= nxt_pc_wr;
		end else if (wr_bit) begin
			pc_out_ff[bit_sel] <= bit_val;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (clear || wr_mode) begin
			irq_enable_flag_a_in_ff <= 1'b0;
			irq_enable_flag_a_out_ff <= 1'b0;
			irq_enable_flag_b_ff <= 1'b0;
		end else if (wr_bit) begin
			if (bit_sel == `PPIO_PC_IRQ_ENABLE_FLAG_A_IN) begin
				irq_enable_flag_a_in_ff <= bit_val;
			end
			if (bit_sel == `PPIO_PC_IRQ_ENABLE_FLAG_A_OUT) begin
				irq_enable_flag_a_out_ff <= bit_val;
			end
			if (bit_sel == `PPIO_PC_IRQ_ENABLE_FLAG_B) begin
				irq_enable_flag_b_ff <= bit_val;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Pin and bus drivers
	// ------------------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (clear) begin
			pa_oe_n_ff <= 8'hff;
			pb_oe_n_ff <= 8'hff;
			pc_oe_n_ff <= 8'hff;
			data_oe_n_ff <= 8'hff;
			data_ff <= `PPIO_DATA_RST;
		end else begin
			pa_oe_n_ff <= {8{pa_is_in}};
			pb_oe_n_ff <= {8{pb_is_in}};
			pc_oe_n_ff <= pc_is_in;
			data_oe_n_ff <= {8{!rd_legal}};
			data_ff <= nxt_data;
		end
	end

	assign o_data = data_ff;
	assign o_data_oe_n = data_oe_n_ff;
	assign o_pa = pa_out_ff;
	assign o_pa_oe_n = pa_oe_n_ff;
	assign o_pb = pb_out_ff;
	assign o_pb_oe_n = pb_oe_n_ff;
	assign o_pc = pc_out_ff;
	assign o_pc_oe_n = pc_oe_n_ff;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	cs_idle_float_a: assert property (!u_bus.rd_en |=> (o_data_oe_n == 8'hff))
		else $error("Data bus driven without a selected read.");

	idle_hold_a: assert property (!u_bus.wr_stb && !clear |=> $stable(o_pa) && $stable(o_pb) && $stable(o_pc))
		else $error("Port output changed without a write.");

	reset_inputs_a: assert property (u_bus.ext_reset |=> (o_pa_oe_n == 8'hff) && (o_pc_oe_n == 8'hff)
		&& (ctrl_ff == `PPIO_CTRL_RST) && (o_pa == 8'h00))
		else $error("Reset did not clear registers and float ports.");

	read_drive_a: assert property (rd_legal |=> (o_data_oe_n == 8'h00)
		&& (o_data == $past(nxt_data)))
		else $error("Selected read did not drive the port value.");

	write_port_a_a: assert property (wr_a && !clear |=> (o_pa == $past(u_bus.wdata)))
		else $error("Port A write not latched.");

	ctrl_read_float_a: assert property (u_bus.rd_en && (u_bus.addr == `PPIO_ADDR_CTRL)
		|=> (o_data_oe_n == 8'hff))
		else $error("Control address read drove the bus.");

	mode_dir_a: assert property (wr_mode && !clear && (u_bus.wdata[6:5] == 2'b00) && !u_bus.wdata[2]
		|=> ##1 (o_pa_oe_n == {8{$past(u_bus.wdata[4], 2)}})
		&& (o_pc_oe_n == {{4{$past(u_bus.wdata[3], 2)}}, {4{$past(u_bus.wdata[0], 2)}}}))
		else $error("Mode 0 word did not set port directions.");

	bit_write_a: assert property (wr_bit && !clear |=> (o_pc[$past(bit_sel)] == $past(bit_val)))
		else $error("Single-bit write did not reach port C.");

	irq_enable_flag_flag_a: assert property (wr_bit && !clear && (bit_sel == `PPIO_PC_IRQ_ENABLE_FLAG_B)
		|=> (irq_enable_flag_b_ff == $past(bit_val)))
		else $error("Enable flag not updated by single-bit write.");

	pc_mask_a: assert property (wr_c && !clear |=> ((o_pc & $past(pc_is_in)) == ($past(o_pc) & $past(pc_is_in))))
		else $error("Port C write altered an input half.");

	mode2_float_a: assert property (cfg_done_ff && (ga_mode == PPIO_MODE2) && !clear
		|=> (o_pa_oe_n == 8'hff) && (o_pc_oe_n[7:3] == 5'h1f))
		else $error("Mode 2 group A drove its pins.");

	// Port B direction follows its own bit once group B is in mode 0.
	pb_dir_a: assert property (wr_mode && !clear && !u_bus.wdata[`PPIO_CW_GB_MODE]
		|=> ##1 (o_pb_oe_n == {8{$past(u_bus.wdata[`PPIO_CW_PB_IN], 2)}}))
		else $error("Mode 0 word did not set port B direction.");

	write_port_b_a: assert property (wr_b && !clear |=> (o_pb == $past(u_bus.wdata)))
		else $error("Port B write not latched.");

	cfg_input_a: assert property (!cfg_done_ff && !clear |=> (o_pb_oe_n == 8'hff) && (o_pc_oe_n == 8'hff))
		else $error("Port driven before the first mode word.");

	irq_enable_flag_out_flag_a: assert property (wr_bit && !clear && (bit_sel == `PPIO_PC_IRQ_ENABLE_FLAG_A_OUT)
		|=> (irq_enable_flag_a_out_ff == $past(bit_val)))
		else $error("Output enable flag not updated by single-bit write.");
endmodule : ppio_port
`default_nettype wire

/* File: ppio_host_model.sv */
// Host processor model that drives the parallel port bus pins.
`default_nettype none
module ppio_host_model (
	input wire logic i_core_clk, // Core clock.
	input wire logic [7:0] i_data, // Data bus value from the device.
	input wire logic [7:0] i_data_oe_n, // Device bus enables, low drives.
	output logic o_cs_n, // Device select.
	output logic o_rd_n, // Read strobe.
	output logic o_wr_n, // Write strobe.
	output logic [1:0] o_addr, // Port address.
	output logic [7:0] o_bus // Resolved data bus seen by the device.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] drv;
	// A released bus shows the inverse of the last byte, so stale data never passes.
	assign o_bus = (i_data & ~i_data_oe_n) | (drv & i_data_oe_n);
	initial begin
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_addr = 2'h0;
		drv = 8'h00;
	end
	task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic sel);
		@(negedge i_core_clk);
		o_cs_n = ~sel;
		o_addr = a;
		drv = d;
		o_wr_n = 1'b0;
		repeat (4) @(negedge i_core_clk);
		o_wr_n = 1'b1;
		repeat (2) @(negedge i_core_clk);
		o_cs_n = 1'b1;
		drv = ~d;
		repeat (6) @(negedge i_core_clk);
	endtask : wr
	// The control address is read only when a test asks for the refusal.
	task automatic rd(input logic [1:0] a, output logic [7:0] d, output logic [7:0] oe_n);
		@(negedge i_core_clk);
		o_cs_n = 1'b0;
		o_addr = a;
		o_rd_n = 1'b0;
		repeat (6) @(negedge i_core_clk);
		d = i_data;
		oe_n = i_data_oe_n;
		o_rd_n = 1'b1;
		o_cs_n = 1'b1;
		repeat (6) @(negedge i_core_clk);
	endtask : rd
endmodule : ppio_host_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking testbench of the parallel port block.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_core_clk;
	logic i_rstn;
	logic dev_reset;
	logic cs_n, rd_n, wr_n;
	logic [1:0] addr;
	logic [7:0] bus, o_data, o_data_oe_n;
	logic [7:0] ext_pa, ext_pb, ext_pc;
	logic [7:0] o_pa, o_pb, o_pc, o_pa_oe_n, o_pb_oe_n, o_pc_oe_n;
	logic [7:0] pa_pin, pb_pin, pc_pin;
	int n_errors = 0;
	int total_checks = 0;
	assign pa_pin = (o_pa & ~o_pa_oe_n) | (ext_pa & o_pa_oe_n);
	assign pb_pin = (o_pb & ~o_pb_oe_n) | (ext_pb & o_pb_oe_n);
	assign pc_pin = (o_pc & ~o_pc_oe_n) | (ext_pc & o_pc_oe_n);
	ppio_host_model host (.i_core_clk(i_core_clk), .i_data(o_data), .i_data_oe_n(o_data_oe_n), .o_cs_n(cs_n),
		.o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr(addr), .o_bus(bus));
	ppio_port dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
		.i_port_select_lo(addr[0]), .i_port_select_hi(addr[1]), .i_reset(dev_reset), .i_data(bus),
		.o_data(o_data), .o_data_oe_n(o_data_oe_n), .i_pa(pa_pin), .o_pa(o_pa), .o_pa_oe_n(o_pa_oe_n),
		.i_pb(pb_pin), .o_pb(o_pb), .o_pb_oe_n(o_pb_oe_n), .i_pc(pc_pin), .o_pc(o_pc), .o_pc_oe_n(o_pc_oe_n));
	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic rdchk(input logic [1:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic [7:0] oe;
		host.rd(a, d, oe);
		check("rd_oe", oe, 8'h00);
		check("rd_data", d, exp);
	endtask : rdchk
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (20000) @(posedge i_core_clk);
		n_errors++;
		complete_run();
	end
	// ----------------------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------------------
	initial begin
		logic [7:0] w, e, d, oe;
		logic [7:0] mw [4];
		logic [7:0] mpa [4];
		logic [7:0] mpc [4];
		mw = '{8'ha0, 8'hc0, 8'h84, 8'hb4};
		mpa = '{8'h00, 8'hff, 8'h00, 8'hff};
		mpc = '{8'hc8, 8'hf8, 8'h07, 8'h3f};
		i_rstn = 1'b0;
		dev_reset = 1'b0;
		ext_pa = 8'h00;
		ext_pb = 8'h00;
		ext_pc = 8'h00;
		repeat (4) @(negedge i_core_clk);
		i_rstn = 1'b1;
		repeat (2) @(negedge i_core_clk);
		check("pa_oe", o_pa_oe_n, 8'hff);
		check("pc_oe", o_pc_oe_n, 8'hff);
		check("bus_oe", o_data_oe_n, 8'hff);
		for (int i = 0; i < 16; i++) begin
			w = {1'b1, 2'b00, i[3], i[2], 1'b0, i[1], i[0]};
			host.wr(2'h3, w, 1'b1);
			check("pa_oe", o_pa_oe_n, {8{w[4]}});
			check("pb_oe", o_pb_oe_n, {8{w[1]}});
			check("pc_oe", o_pc_oe_n, {{4{w[3]}}, {4{w[0]}}});
		end
		host.wr(2'h3, 8'h80, 1'b1);
		host.wr(2'h0, 8'h5a, 1'b1);
		host.wr(2'h1, 8'ha5, 1'b1);
		host.wr(2'h2, 8'h3c, 1'b1);
		check("pa", o_pa, 8'h5a);
		check("pb", o_pb, 8'ha5);
		check("pc", o_pc, 8'h3c);
		rdchk(2'h0, 8'h5a);
		rdchk(2'h1, 8'ha5);
		rdchk(2'h2, 8'h3c);
		host.wr(2'h0, 8'hff, 1'b0);
		check("pa_desel", o_pa, 8'h5a);
		host.rd(2'h3, d, oe);
		check("ctrl_rd_oe", oe, 8'hff);
		e = 8'h3c;
		for (int i = 0; i < 8; i++) begin
			e[i] = ~e[i];
			host.wr(2'h3, {4'h0, i[2:0], e[i]}, 1'b1);
			check("pc_bit", o_pc, e);
		end
		check("pc_oe_bit", o_pc_oe_n, 8'h00);
		host.wr(2'h3, 8'h9b, 1'b1);
		ext_pa = 8'hc3;
		ext_pb = 8'h96;
		ext_pc = 8'he1;
		rdchk(2'h0, 8'hc3);
		ext_pa = 8'h3c;
		rdchk(2'h0, 8'h3c);
		rdchk(2'h1, 8'h96);
		rdchk(2'h2, 8'he1);
		host.wr(2'h3, 8'h88, 1'b1);
		host.wr(2'h2, 8'hff, 1'b1);
		check("pc_low", o_pc & 8'h0f, 8'h0f);
		rdchk(2'h2, 8'hef);
		for (int i = 0; i < 4; i++) begin
			host.wr(2'h3, mw[i], 1'b1);
			check("hs_pa_oe", o_pa_oe_n, mpa[i]);
			check("hs_pc_oe", o_pc_oe_n, mpc[i]);
			check("hs_pb_oe", o_pb_oe_n, 8'h00);
		end
		host.wr(2'h3, 8'ha0, 1'b1);
		host.wr(2'h3, 8'h0d, 1'b1);
		host.rd(2'h2, d, oe);
		check("flag_set", d & 8'h40, 8'h40);
		host.wr(2'h3, 8'h0c, 1'b1);
		host.rd(2'h2, d, oe);
		check("flag_clr", d & 8'h40, 8'h00);
		host.wr(2'h3, 8'h80, 1'b1);
		host.wr(2'h0, 8'h5a, 1'b1);
		dev_reset = 1'b1;
		repeat (6) @(negedge i_core_clk);
		check("rst_pa_oe", o_pa_oe_n, 8'hff);
		check("rst_pb_oe", o_pb_oe_n, 8'hff);
		check("rst_pa", o_pa, 8'h00);
		dev_reset = 1'b0;
		repeat (6) @(negedge i_core_clk);
		complete_run();
	end
endmodule : testbench
`default_nettype wire
